/* src/sai_pkg.sv */
// Shared constants and types for the serial audio input port.
// Assumes a single peripheral clock domain on the FIFO side.

package sai_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int CHANNELS    = 8;
   localparam int CHAN_BITS   = 3;
   localparam int WORD_BITS   = 32;
   localparam int FRAME_BITS  = 64;
   localparam int HALF_BITS   = FRAME_BITS / 2;
   localparam int COUNT_BITS  = 6;
   localparam int FIFO_DEPTH  = 8;
   localparam int ENTRY_BITS  = CHAN_BITS + 1 + WORD_BITS;

   // ----------------------------------------------------------------
   // Entry field positions
   // ----------------------------------------------------------------
   localparam int ENTRY_WORD_LSB = 0;
   localparam int ENTRY_LEFT_POS = WORD_BITS;
   localparam int ENTRY_CHAN_LSB = WORD_BITS + 1;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [WORD_BITS-1:0]  WORD_RESET  = 32'h0000_0000;
   localparam logic [COUNT_BITS-1:0] COUNT_RESET = 6'h00;

   // ----------------------------------------------------------------
   // Framing formats and sample widths
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SAI_FMT_I2S = 2'h0,
      SAI_FMT_LJ  = 2'h1,
      SAI_FMT_RJ  = 2'h2
   } sai_format_t;

   typedef enum logic [2:0] {
      SAI_WID_32 = 3'h0,
      SAI_WID_24 = 3'h1,
      SAI_WID_20 = 3'h2,
      SAI_WID_18 = 3'h3,
      SAI_WID_16 = 3'h4
   } sai_width_t;

endpackage : sai_pkg

/* src/sai_stream_if.sv */
// Valid/ready word stream between the port's own modules.
// Assumes both ends sit on the same clock.

`timescale 1ns/1ps

interface sai_stream_if #(parameter int WIDTH = 36);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface : sai_stream_if

/* src/sai_fifo.sv */
// Synchronous word FIFO with valid/ready on both sides.
// Assumes fill and drain share one clock and a synchronous reset.

`timescale 1ns/1ps

module sai_fifo
   import sai_pkg::*;
#(
   parameter int WIDTH = ENTRY_BITS,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic     clock,
   input wire logic     sys_rst,
   sai_stream_if.sink   fillPort,
   sai_stream_if.source drainPort
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      count;
   logic             doPush;
   logic             doPop;

   // ----------------------------------------------------------------
   // Handshake
   // ----------------------------------------------------------------
   assign fillPort.ready  = (count != (AW+1)'(DEPTH));
   assign drainPort.valid = (count != '0);
   assign drainPort.data  = mem[rdPtr];
   assign doPush          = fillPort.valid & fillPort.ready;
   assign doPop           = drainPort.valid & drainPort.ready;

   // Storage; no reset needed, contents gated by count
   always_ff @(posedge clock)
   begin
      if (doPush)
      begin
         mem[wrPtr] <= fillPort.data;
      end
   end

   // Pointers wrap explicitly so depth need not be a power of two
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
      end
      else
      begin
         if (doPush)
         begin
            wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         end
         if (doPop)
         begin
            rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         end
      end
   end

   // Occupancy
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         count <= '0;
      end
      else if (doPush && !doPop)
      begin
         count <= count + 1'b1;
      end
      else if (doPop && !doPush)
      begin
         count <= count - 1'b1;
      end
   end

endmodule : sai_fifo

/* src/sai_input_port.sv */
// Serial audio input port: eight receive channels into one word FIFO.
// Assumes link pins are asynchronous to clock and toggle far slower than it.

`timescale 1ns/1ps

module sai_input_port
   import sai_pkg::*;
#(
   parameter int NUM_CHANNELS = CHANNELS,
   parameter int DEPTH        = FIFO_DEPTH
)
(
   input  wire logic                                 clock,
   input  wire logic                                 sys_rst,
   input  wire logic [NUM_CHANNELS-1:0]              chanBitClock,
   input  wire logic [NUM_CHANNELS-1:0]              chanFrameSync,
   input  wire logic [NUM_CHANNELS-1:0]              chanData,
   input  wire logic [NUM_CHANNELS-1:0]              chanEnable,
   input  wire logic [NUM_CHANNELS-1:0][1:0]         chanFormat,
   input  wire logic [NUM_CHANNELS-1:0][2:0]         chanWidth,
   output wire logic [WORD_BITS-1:0]                 wordData,
   output wire logic [CHAN_BITS-1:0]                 wordChannel,
   output wire logic                                 wordLeft,
   output wire logic                                 wordValid,
   input  wire logic                                 wordReady,
   output logic                                      overflow,
   input  wire logic                                 overflowClear
);

   // ----------------------------------------------------------------
   // Sample alignment
   // ----------------------------------------------------------------
   // Puts every format MSB-first at bit 31; RJ zeroes unused low bits (RJ 32 is handled as 24), I2S/LJ below 32 bits clears only bits 7:0
   function automatic logic [WORD_BITS-1:0] alignWord(
      input logic [1:0]           fmt,
      input logic [2:0]           wid,
      input logic [WORD_BITS-1:0] raw
   );
      logic [WORD_BITS-1:0] res;
      res = raw;
      if (fmt == SAI_FMT_RJ)
      begin
         case (wid)
            SAI_WID_16: res = {raw[15:0], 16'h0000};
            SAI_WID_18: res = {raw[17:0], 14'h0000};
            SAI_WID_20: res = {raw[19:0], 12'h000};
            default:    res = {raw[23:0], 8'h00};                 // 24 and any other
         endcase
      end
      else if (wid != SAI_WID_32)
      begin
         res = {raw[31:8], 8'h00};                                // I2S/LJ below 32 bits, low 8 cleared
      end
      return res;
   endfunction : alignWord

   // ----------------------------------------------------------------
   // Per-channel state visible to the arbiter
   // ----------------------------------------------------------------
   logic [NUM_CHANNELS-1:0]                 pend;
   logic [NUM_CHANNELS-1:0]                 pendLeft;
   logic [NUM_CHANNELS-1:0][WORD_BITS-1:0]  pendWord;
   logic [NUM_CHANNELS-1:0]                 chanLost;
   logic [NUM_CHANNELS-1:0]                 grant;
   logic [CHAN_BITS-1:0]                    grantIdx;
   logic                                    anyPend;

   sai_stream_if #(.WIDTH(ENTRY_BITS)) fillBus ();
   sai_stream_if #(.WIDTH(ENTRY_BITS)) drainBus ();

   // ----------------------------------------------------------------
   // Receive channels
   // ----------------------------------------------------------------
   for (genvar ch = 0; ch < NUM_CHANNELS; ch++)
   begin : g_chan
      logic                   clkMeta, clkStable, clkLast;
      logic                   fsMeta, fsStable, fsPrev;
      logic                   datMeta, datStable;
      logic [WORD_BITS-1:0]   shiftReg;
      logic [COUNT_BITS-1:0]  bitCount;
      logic                   delayPend;
      logic                   delaySide;
      logic                   bitRise;
      logic                   fsChange;
      logic                   halfFull;
      logic                   emit;
      logic                   emitSide;
      logic [WORD_BITS-1:0]   emitRaw;

      // Two-flop synchronisers; the first stage feeds only the second
      always_ff @(posedge clock)
      begin
         if (sys_rst)
         begin
            clkMeta   <= 1'b0;
            clkStable <= 1'b0;
            clkLast   <= 1'b0;
            fsMeta    <= 1'b0;
            fsStable  <= 1'b0;
            datMeta   <= 1'b0;
            datStable <= 1'b0;
         end
         else
         begin
            clkMeta   <= chanBitClock[ch];
            clkStable <= clkMeta;
            clkLast   <= clkStable;
            fsMeta    <= chanFrameSync[ch];
            fsStable  <= fsMeta;
            datMeta   <= chanData[ch];
            datStable <= datMeta;
         end
      end

      // Bit clock rising edge; frame sync edge marks a half-frame boundary
      assign bitRise  = clkStable & ~clkLast;
      assign fsChange = bitRise & (fsStable != fsPrev);
      assign halfFull = (bitCount == COUNT_BITS'(HALF_BITS));

      // Shift in serial data, count bits since the last frame sync edge
      always_ff @(posedge clock)
      begin
         if (sys_rst || !chanEnable[ch])
         begin
            shiftReg <= WORD_RESET;
            bitCount <= COUNT_RESET;
            fsPrev   <= 1'b0;
         end
         else if (bitRise)
         begin
            shiftReg <= {shiftReg[WORD_BITS-2:0], datStable};
            fsPrev   <= fsStable;
            if (fsChange)
            begin
               bitCount <= COUNT_BITS'(1);
            end
            else if (!halfFull)
            begin
               bitCount <= bitCount + 1'b1;                             // Saturates at a half
            end
         end
      end

      // I2S data trails the frame sync by one bit, so its word closes an edge later
      always_ff @(posedge clock)
      begin
         if (sys_rst || !chanEnable[ch])
         begin
            delayPend <= 1'b0;
            delaySide <= 1'b0;
         end
         else if (bitRise)
         begin
            delayPend <= fsChange & halfFull & (chanFormat[ch] == SAI_FMT_I2S);
            delaySide <= ~fsPrev;                                       // I2S left is sync low
         end
      end

      // Word completion: one per finished half frame
      always_comb
      begin
         emit     = 1'b0;
         emitSide = fsPrev;
         emitRaw  = shiftReg;
         if (bitRise && delayPend)
         begin
            emit     = 1'b1;
            emitSide = delaySide;
            emitRaw  = shiftReg;                                        // I2S, 32 bits after sync edge
         end
         else if (fsChange && halfFull && (chanFormat[ch] != SAI_FMT_I2S))
         begin
            emit     = 1'b1;                                            // LJ and RJ
            emitSide = fsPrev;                                          // Left is sync high
            emitRaw  = shiftReg;
         end
      end

      // Holding slot; a new word overwrites one not yet taken
      always_ff @(posedge clock)
      begin
         if (sys_rst || !chanEnable[ch])
         begin
            pend[ch]     <= 1'b0;
            pendLeft[ch] <= 1'b0;
            pendWord[ch] <= WORD_RESET;
         end
         else if (emit)
         begin
            pend[ch]     <= 1'b1;                                       // Set beats grant
            pendLeft[ch] <= emitSide;
            pendWord[ch] <= alignWord(chanFormat[ch], chanWidth[ch], emitRaw);
         end
         else if (grant[ch])
         begin
            pend[ch] <= 1'b0;
         end
      end

      assign chanLost[ch] = emit & pend[ch] & ~grant[ch];
   end

   // ----------------------------------------------------------------
   // Channel multiplexer
   // ----------------------------------------------------------------
   // Fixed priority, lowest channel first; half frames last hundreds of
   // cycles so every channel is served long before its next word
   always_comb
   begin
      grant    = '0;
      grantIdx = '0;
      anyPend  = 1'b0;
      for (int i = NUM_CHANNELS - 1; i >= 0; i--)
      begin
         if (pend[i])
         begin
            grantIdx = CHAN_BITS'(i);
            anyPend  = 1'b1;
         end
      end
      if (anyPend)
      begin
         grant[grantIdx] = 1'b1;
      end
   end

   // Granted word is offered once; a full FIFO drops it
   assign fillBus.valid = anyPend;
   assign fillBus.data  = {grantIdx, pendLeft[grantIdx], pendWord[grantIdx]};

   // ----------------------------------------------------------------
   // Overflow flag
   // ----------------------------------------------------------------
   // Sticky; a new loss in the clear cycle keeps it set
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         overflow <= 1'b0;
      end
      else if ((anyPend && !fillBus.ready) || (chanLost != '0))
      begin
         overflow <= 1'b1;
      end
      else if (overflowClear)
      begin
         overflow <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Shared FIFO
   // ----------------------------------------------------------------
   sai_fifo #(
      .WIDTH (ENTRY_BITS),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .fillPort  (fillBus),
      .drainPort (drainBus)
   );

   assign drainBus.ready = wordReady;
   assign wordValid      = drainBus.valid;
   assign wordData       = drainBus.data[ENTRY_WORD_LSB +: WORD_BITS];
   assign wordLeft       = drainBus.data[ENTRY_LEFT_POS];
   assign wordChannel    = drainBus.data[ENTRY_CHAN_LSB +: CHAN_BITS];

endmodule : sai_input_port

/* verification/sai_input_port_sva.sv */
// Assertions on the FIFO side of the serial audio input port.
// Assumes binding onto sai_input_port; link pins are only watched.
`timescale 1ns/1ps
module sai_input_port_chk
   import sai_pkg::*;
#(
   parameter int NUM_CHANNELS = CHANNELS,
   parameter int DEPTH        = FIFO_DEPTH
)
(
   input wire logic                         clock,
   input wire logic                         sys_rst,
   input wire logic [NUM_CHANNELS-1:0]      chanBitClock,
   input wire logic [NUM_CHANNELS-1:0]      chanFrameSync,
   input wire logic [NUM_CHANNELS-1:0]      chanData,
   input wire logic [NUM_CHANNELS-1:0]      chanEnable,
   input wire logic [NUM_CHANNELS-1:0][1:0] chanFormat,
   input wire logic [NUM_CHANNELS-1:0][2:0] chanWidth,
   input wire logic [WORD_BITS-1:0]         wordData,
   input wire logic [CHAN_BITS-1:0]         wordChannel,
   input wire logic                         wordLeft,
   input wire logic                         wordValid,
   input wire logic                         wordReady,
   input wire logic                         overflow,
   input wire logic                         overflowClear
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   // --------
   // Checks
   // --------
   a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !wordValid && !overflow)
      else $error("not empty after reset");
   a_head_stable: assert property (wordValid && !wordReady |=> wordValid && $stable(wordData)
      && $stable(wordChannel) && $stable(wordLeft))
      else $error("head word moved without pop");
   a_rj16_zero: assert property (wordValid && chanFormat[wordChannel] == SAI_FMT_RJ
      && chanWidth[wordChannel] == SAI_WID_16 |-> wordData[15:0] == 16'h0000)
      else $error("short sample has stray low bits");
   a_w24_zero: assert property (wordValid && chanWidth[wordChannel] == SAI_WID_24
      |-> wordData[7:0] == 8'h00)
      else $error("24 bit sample has stray low bits");
   a_ovf_sticky: assert property (overflow && !overflowClear |=> overflow)
      else $error("overflow dropped on its own");
   a_ovf_clear: assert property (overflowClear && !wordValid |=> !overflow)
      else $error("overflow not cleared");
   a_ovf_cause: assert property ($rose(overflow) |-> $past(wordValid))
      else $error("overflow with empty buffer");
   a_idle_quiet: assert property (chanEnable == '0 && !wordValid |=> !wordValid)
      else $error("word from disabled channels");

   // Main scenarios reached
   cover property ($rose(overflow));
   cover property (wordValid && wordReady && !wordLeft);
   cover property (wordValid && chanFormat[wordChannel] == SAI_FMT_RJ);
endmodule : sai_input_port_chk

bind sai_input_port sai_input_port_chk #(.NUM_CHANNELS(NUM_CHANNELS), .DEPTH(DEPTH)) i_chk (
   .clock(clock), .sys_rst(sys_rst), .chanBitClock(chanBitClock),
   .chanFrameSync(chanFrameSync), .chanData(chanData), .chanEnable(chanEnable),
   .chanFormat(chanFormat), .chanWidth(chanWidth), .wordData(wordData),
   .wordChannel(wordChannel), .wordLeft(wordLeft), .wordValid(wordValid),
   .wordReady(wordReady), .overflow(overflow), .overflowClear(overflowClear));

/* verification/sai_audio_source.sv */
// Behavioural serial audio source for one receive channel.
// Bit clock stands still between frames; lines change on its falling edge.
`timescale 1ns/1ps
module sai_audio_source
   import sai_pkg::*;
(
   input  wire logic        start,
   input  wire logic [1:0]  fmt,
   input  wire logic [31:0] leftSlot,
   input  wire logic [31:0] rightSlot,
   output logic             bitClock,
   output logic             frameSync,
   output logic             serData,
   output logic             busy
);
   logic        leftLvl;
   logic [63:0] pairBits;
   int          pos;

   // Short lead half (dropped), left, right, two bits to close the pair
   initial
   begin
      bitClock = 1'b0;
      frameSync = 1'b1;
      serData = 1'b0;
      busy = 1'b0;
      #37;
      forever
      begin
         @(posedge start);
         busy = 1'b1;
         leftLvl = (fmt != SAI_FMT_I2S);
         pairBits = {leftSlot, rightSlot};
         for (int i = 0; i < 70; i++)
         begin
            #200 bitClock = 1'b0;
            frameSync = ((i >= 4 && i < 36) || i >= 68) ? leftLvl : ~leftLvl;
            pos = i - 4 - int'(fmt == SAI_FMT_I2S);
            serData = (pos >= 0 && pos < 64) ? pairBits[63 - pos] : ~serData;
            #200 bitClock = 1'b1;
         end
         #200 bitClock = 1'b0;
         serData = ~serData;   // No stale bit once released
         busy = 1'b0;
      end
   end
endmodule : sai_audio_source

/* verification/tb_sai_input_port.sv */
// Bench for the serial audio input port: eight sources, FIFO drained here.
// Assumes the source model and the design files are compiled first.
`timescale 1ns/1ps
module tb_sai_input_port
   import sai_pkg::*;
;
   logic                 clock;
   logic                 sys_rst;
   logic [7:0]           chanBitClock;
   logic [7:0]           chanFrameSync;
   logic [7:0]           chanData;
   logic [7:0]           chanEnable;
   logic [7:0][1:0]      chanFormat;
   logic [7:0][2:0]      chanWidth;
   logic [WORD_BITS-1:0] wordData;
   logic [CHAN_BITS-1:0] wordChannel;
   logic                 wordLeft;
   logic                 wordValid;
   logic                 wordReady;
   logic                 overflow;
   logic                 overflowClear;
   logic [7:0]           srcStart;
   logic [7:0]           srcBusy;
   logic [7:0][31:0]     leftSlot;
   logic [7:0][31:0]     rightSlot;
   int                   failures;
   int                   checked;
   localparam int WID_TAB [8] = '{32, 24, 32, 24, 24, 20, 18, 16};
   localparam logic [2:0] WCODE [8] = '{3'h0, 3'h1, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4};
   localparam logic [31:0] SRC_L = 32'hA5C3_961E;
   localparam logic [31:0] SRC_R = 32'h5A3C_69E1;

   // 50 ns system clock
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   sai_input_port i_sai_input_port (.clock(clock), .sys_rst(sys_rst),
      .chanBitClock(chanBitClock), .chanFrameSync(chanFrameSync), .chanData(chanData),
      .chanEnable(chanEnable), .chanFormat(chanFormat), .chanWidth(chanWidth),
      .wordData(wordData), .wordChannel(wordChannel), .wordLeft(wordLeft),
      .wordValid(wordValid), .wordReady(wordReady), .overflow(overflow),
      .overflowClear(overflowClear));

   // One source per channel, each with its own bit clock
   for (genvar c = 0; c < 8; c++)
   begin : g_src
      sai_audio_source i_sai_audio_source (.start(srcStart[c]), .fmt(chanFormat[c]),
         .leftSlot(leftSlot[c]), .rightSlot(rightSlot[c]), .bitClock(chanBitClock[c]),
         .frameSync(chanFrameSync[c]), .serData(chanData[c]), .busy(srcBusy[c]));
   end

   // --------
   // Helpers
   // --------
   task automatic give_verdict();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict

   task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_bit(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   // Send one pair on each masked channel; 20 cycles cover the push path
   task automatic run_frames(input logic [7:0] mask);
      int n;
      n = 0;
      @(posedge clock);
      #1 srcStart = mask;
      @(posedge clock);
      #1 srcStart = 8'h00;
      while (srcBusy !== 8'h00 && n < 1000)
      begin
         @(posedge clock);
         #1 n++;
      end
      if (srcBusy !== 8'h00)
      begin
         failures++;
         give_verdict();
      end
      repeat (20) @(posedge clock);
      #1;
   endtask : run_frames

   // Wait for a head word, judge it, pop it
   task automatic pop_check(input logic [31:0] expData, input int ch, input logic expLeft);
      int n;
      n = 0;
      while (wordValid !== 1'b1 && n < 100)
      begin
         @(posedge clock);
         #1 n++;
      end
      if (wordValid !== 1'b1)
      begin
         failures++;
         give_verdict();
      end
      check_word("wordData", expData, wordData);
      check_word("wordChannel", 32'(ch), {29'h0000_0000, wordChannel});
      check_bit("wordLeft", expLeft, wordLeft);
      wordReady = 1'b1;
      @(posedge clock);
      #1 wordReady = 1'b0;
      // Let an edge pass so a following pop never re-raises ready at once
      @(posedge clock);
      #1;
   endtask : pop_check

   // --------
   // Scenarios
   // --------
   task automatic test_reset();
      check_bit("wordValid", 1'b0, wordValid);
      check_bit("overflow", 1'b0, overflow);
      $display("test_reset done");
   endtask : test_reset

   // I2S and LJ at 32 and 24, RJ at 24, 20, 18 and 16 bits on channel 0; RJ padding bits sent as ones
   task automatic test_formats();
      logic [31:0] lowMask;
      logic [31:0] expL;
      logic [31:0] expR;
      int          w;
      for (int k = 0; k < 8; k++)
      begin
         w = WID_TAB[k];
         chanFormat[0] = (k < 2) ? SAI_FMT_I2S : (k < 4) ? SAI_FMT_LJ : SAI_FMT_RJ;
         chanWidth[0] = WCODE[k];
         lowMask = ~(32'hFFFF_FFFF << w);
         leftSlot[0] = (k < 4) ? SRC_L : (SRC_L | ~lowMask);
         rightSlot[0] = (k < 4) ? SRC_R : (SRC_R | ~lowMask);
         expL = (k < 4) ? (SRC_L & ~(32'hFFFF_FFFF >> w)) : ((SRC_L & lowMask) << (32 - w));
         expR = (k < 4) ? (SRC_R & ~(32'hFFFF_FFFF >> w)) : ((SRC_R & lowMask) << (32 - w));
         run_frames(8'h01);
         pop_check(expL, 0, 1'b1);
         pop_check(expR, 0, 1'b0);
      end
      check_bit("wordValid", 1'b0, wordValid);
      $display("test_formats done");
   endtask : test_formats

   // Four channels at once fill the buffer exactly while stalled
   task automatic test_mux();
      chanFormat = {8{2'h1}};
      chanWidth = '0;
      for (int c = 0; c < 8; c++)
      begin
         leftSlot[c] = 32'h1357_9BDF ^ {4{8'(c)}};
         rightSlot[c] = ~leftSlot[c];
      end
      run_frames(8'h0F);
      for (int c = 0; c < 4; c++)
         pop_check(leftSlot[c], c, 1'b1);
      for (int c = 0; c < 4; c++)
         pop_check(rightSlot[c], c, 1'b0);
      check_bit("wordValid", 1'b0, wordValid);
      check_bit("overflow", 1'b0, overflow);
      $display("test_mux done");
   endtask : test_mux

   // Sixteen words into eight places: rights lost, flag sticks
   task automatic test_overflow();
      run_frames(8'hFF);
      check_bit("overflow", 1'b1, overflow);
      for (int c = 0; c < 8; c++)
         pop_check(leftSlot[c], c, 1'b1);
      check_bit("wordValid", 1'b0, wordValid);
      check_bit("overflow", 1'b1, overflow);
      overflowClear = 1'b1;
      @(posedge clock);
      #1 overflowClear = 1'b0;
      check_bit("overflow", 1'b0, overflow);
      $display("test_overflow done");
   endtask : test_overflow

   // Disabled channel yields nothing; after enable it works again
   task automatic test_disable();
      chanEnable = 8'h00;
      run_frames(8'h02);
      check_bit("wordValid", 1'b0, wordValid);
      chanEnable = 8'hFF;
      run_frames(8'h02);
      pop_check(leftSlot[1], 1, 1'b1);
      pop_check(rightSlot[1], 1, 1'b0);
      $display("test_disable done");
   endtask : test_disable

   // Main sequence
   initial
   begin
      sys_rst = 1'b1;
      wordReady = 1'b0;
      overflowClear = 1'b0;
      chanEnable = 8'hFF;
      chanFormat = {8{2'h1}};
      chanWidth = '0;
      srcStart = 8'h00;
      leftSlot = '0;
      rightSlot = '0;
      failures = 0;
      checked = 0;
      repeat (3) @(posedge clock);
      #1 sys_rst = 1'b0;
      test_reset();
      test_formats();
      test_mux();
      test_overflow();
      test_disable();
      give_verdict();
   end
endmodule : tb_sai_input_port
